// ### src/period_meter_consts.svh
/*
 * constants of the period meter: register offsets, field positions,
 * reset values and timing figures.
 * assumes a 50 MHz module clock and a 32-bit AXI4-Lite register port.
 */
`ifndef PERIOD_METER_CONSTS_SVH
`define PERIOD_METER_CONSTS_SVH

// register byte offsets
`define PM_CTRL_OFS      8'h00
`define PM_SEL_OFS       8'h04
`define PM_PERIOD_OFS    8'h08
`define PM_STATUS_OFS    8'h0c
`define PM_LIVE_OFS      8'h10
`define PM_REFLEX_BASE   8'h20
`define PM_REFLEX_STRIDE 8'h08
`define PM_REFLEX_MODE   8'h04

// control register fields
`define PM_CTRL_EN_GATE   0
`define PM_CTRL_VARIANT   1
`define PM_CTRL_RES_LO    2
`define PM_CTRL_CMP_EN    5
`define PM_CTRL_CMP_SUSP  6
`define PM_CTRL_FORCE_EN  7
`define PM_CTRL_RESET     8'h00

// select register fields
`define PM_SEL_MEAS_LO    0
`define PM_SEL_GATE_LO    4
`define PM_SEL_RESET      8'h00

// status register fields
`define PM_ST_RUN         0
`define PM_ST_VALID       1
`define PM_ST_BUSY        2
`define PM_ST_READY       3
`define PM_ST_REFLEX_LO   4

// timing figures
`define PM_CLK_NS         20
`define PM_RES0_NS        100
`define PM_RES1_NS        1000
`define PM_RES2_NS        10000
`define PM_RES3_NS        100000
`define PM_RES4_NS        1000000
`define PM_RES0_CYC       ((`PM_RES0_NS) / (`PM_CLK_NS))
`define PM_RES1_CYC       ((`PM_RES1_NS) / (`PM_CLK_NS))
`define PM_RES2_CYC       ((`PM_RES2_NS) / (`PM_CLK_NS))
`define PM_RES3_CYC       ((`PM_RES3_NS) / (`PM_CLK_NS))
`define PM_RES4_CYC       ((`PM_RES4_NS) / (`PM_CLK_NS))
`define PM_REFLEX_MAX_NS  20000
`define PM_REFLEX_MAX_CYC ((`PM_REFLEX_MAX_NS) / (`PM_CLK_NS))

`endif

// ### src/period_meter_pkg.sv
/*
 * types shared by the period meter files.
 * assumes the constants header for all numeric values.
 */
package period_meter_pkg;

    typedef enum logic [1:0] {
        MEAS_IDLE   = 2'b00,
        MEAS_ARMED  = 2'b01,
        MEAS_TIMING = 2'b10
    } meas_state_e;

    typedef enum logic [2:0] {
        RES_0US1 = 3'b000,
        RES_1US  = 3'b001,
        RES_10US = 3'b010,
        RES_100US = 3'b011,
        RES_1MS  = 3'b100
    } resolution_e;

    typedef enum logic [1:0] {
        TRIG_OFF   = 2'b00,
        TRIG_AT_OR_ABOVE = 2'b01,
        TRIG_BELOW = 2'b10,
        TRIG_EQUAL = 2'b11
    } trigger_e;

endpackage

// ### src/tick_divider.sv
/*
 * resolution tick divider: one-cycle tick every period_cyc clocks.
 * assumes period_cyc stays stable while running; restart realigns it.
 */
`timescale 1ns/1ps
module tick_divider #(
    parameter int W = 16
) (
    input  wire logic         clock,      // module clock
    input  wire logic         rst_b,      // async reset, active low
    input  wire logic         restart,    // realign phase to zero
    input  wire logic [W-1:0] period_cyc, // clocks per tick
    output logic              tick        // one-cycle tick pulse
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         tick_d;

    always_comb begin
        cnt_d  = cnt_q + W'(1);
        tick_d = 1'b0;
        if (restart) begin
            cnt_d = '0;
        end else if (cnt_q >= period_cyc - W'(1)) begin
            cnt_d  = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick  <= tick_d;
        end
    end
endmodule

// ### src/period_meter_capture.sv
/*
 * period meter channel: times pulses or periods of one field input,
 * publishes the count, and drives reflex outputs from the live count.
 * assumes field inputs synchronous to clock and filtered upstream.
 */
`timescale 1ns/1ps
`include "period_meter_consts.svh"
module period_meter_capture #(
    parameter int N_IN          = 12,
    parameter int N_REFLEX      = 4,
    parameter int TICK_100US_CYC = `PM_RES3_CYC,
    parameter int TICK_1MS_CYC  = `PM_RES4_CYC
) (
    input  wire logic                clock,         // 50 MHz clock
    input  wire logic                rst_b,         // async reset, low
    input  wire logic [N_IN-1:0]     field_in,      // filtered inputs
    output logic [N_REFLEX-1:0]      reflex_out,    // reflex outputs
    input  wire logic [7:0]          s_axi_awaddr,  // write address
    input  wire logic                s_axi_awvalid, // write addr valid
    output logic                     s_axi_awready, // write addr ready
    input  wire logic [31:0]         s_axi_wdata,   // write data
    input  wire logic [3:0]          s_axi_wstrb,   // byte enables
    input  wire logic                s_axi_wvalid,  // write data valid
    output logic                     s_axi_wready,  // write data ready
    output logic [1:0]               s_axi_bresp,   // write response
    output logic                     s_axi_bvalid,  // response valid
    input  wire logic                s_axi_bready,  // response ready
    input  wire logic [7:0]          s_axi_araddr,  // read address
    input  wire logic                s_axi_arvalid, // read addr valid
    output logic                     s_axi_arready, // read addr ready
    output logic [31:0]              s_axi_rdata,   // read data
    output logic [1:0]               s_axi_rresp,   // read response
    output logic                     s_axi_rvalid,  // read data valid
    input  wire logic                s_axi_rready   // read data ready
);
    localparam logic [1:0] RESP_OK  = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;

    // configuration and bus state
    logic [7:0]  ctrl_q, ctrl_d, sel_q, sel_d;
    logic [31:0] thr_q [N_REFLEX];
    logic [31:0] thr_d [N_REFLEX];
    logic [1:0]  mode_q [N_REFLEX];
    logic [1:0]  mode_d [N_REFLEX];
    logic [7:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic        aw_held_q, aw_held_d, w_held_q, w_held_d;
    logic        awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic [1:0]  bresp_d, rresp_d;
    logic [31:0] rdata_d;

    // measurement state
    period_meter_pkg::meas_state_e st_q, st_d;
    logic [31:0] cnt_q, cnt_d, period_q, period_d;
    logic        valid_q, valid_d, prev_q, prev_d;

    // input selection and enable condition
    logic [3:0]  meas_sel, gate_sel;
    logic [N_IN:0] pins_ext;
    logic        meas_ok, gate_ok, meas_pin, gate_pin, enable_cond;
    logic        rise, fall, variant_edge, div_restart, tick;
    logic [15:0] tick_cyc;

    assign meas_sel = sel_q[`PM_SEL_MEAS_LO +: 4];
    assign gate_sel = sel_q[`PM_SEL_GATE_LO +: 4];
    assign pins_ext = {field_in, 1'b0};
    // select value zero means unassigned; out-of-range acts the same
    assign meas_ok  = (meas_sel != 4'h0) && (32'(meas_sel) <= N_IN);
    assign gate_ok  = (gate_sel != 4'h0) && (32'(gate_sel) <= N_IN);
    assign meas_pin = meas_ok ? pins_ext[meas_sel] : 1'b0;
    assign gate_pin = gate_ok ? pins_ext[gate_sel] : 1'b0;
    assign enable_cond = ctrl_q[`PM_CTRL_FORCE_EN] ||
        (ctrl_q[`PM_CTRL_EN_GATE] && gate_ok && gate_pin);
    assign rise = meas_pin && !prev_q;
    assign fall = !meas_pin && prev_q;
    assign variant_edge = ctrl_q[`PM_CTRL_VARIANT];

    always_comb begin
        case (period_meter_pkg::resolution_e'(ctrl_q[`PM_CTRL_RES_LO +: 3]))
            period_meter_pkg::RES_0US1:  tick_cyc = 16'(`PM_RES0_CYC);
            period_meter_pkg::RES_1US:   tick_cyc = 16'(`PM_RES1_CYC);
            period_meter_pkg::RES_10US:  tick_cyc = 16'(`PM_RES2_CYC);
            period_meter_pkg::RES_100US: tick_cyc = 16'(TICK_100US_CYC);
            period_meter_pkg::RES_1MS:   tick_cyc = 16'(TICK_1MS_CYC);
            default:                     tick_cyc = 16'(`PM_RES1_CYC);
        endcase
    end

    // tick phase starts afresh with each measurement
    assign div_restart = rise;
    tick_divider #(
        .W (16)
    ) u_tick (
        .clock      (clock),
        .rst_b      (rst_b),
        .restart    (div_restart),
        .period_cyc (tick_cyc),
        .tick       (tick)
    );

    // measurement sequencer
    always_comb begin
        st_d     = st_q;
        cnt_d    = cnt_q;
        period_d = period_q;
        valid_d  = valid_q && enable_cond;
        prev_d   = meas_pin;
        if (!meas_ok || !enable_cond) begin
            st_d = period_meter_pkg::MEAS_IDLE;
        end else begin
            case (st_q)
                period_meter_pkg::MEAS_IDLE: begin
                    // wait for the input to be seen once before arming
                    st_d = period_meter_pkg::MEAS_ARMED;
                end
                period_meter_pkg::MEAS_ARMED: begin
                    if (rise) begin
                        st_d  = period_meter_pkg::MEAS_TIMING;
                        cnt_d = '0;
                    end
                end
                period_meter_pkg::MEAS_TIMING: begin
                    if (tick && cnt_q != 32'hffff_ffff) begin
                        cnt_d = cnt_q + 32'h1;
                    end
                    if (!variant_edge && fall) begin
                        period_d = cnt_q;
                        valid_d  = 1'b1;
                        st_d     = period_meter_pkg::MEAS_ARMED;
                    end else if (variant_edge && rise) begin
                        period_d = cnt_q;
                        valid_d  = 1'b1;
                        cnt_d    = '0;
                    end
                end
                default: st_d = period_meter_pkg::MEAS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q     <= period_meter_pkg::MEAS_IDLE;
            cnt_q    <= '0;
            period_q <= '0;
            valid_q  <= 1'b0;
            prev_q   <= 1'b0;
        end else begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            period_q <= period_d;
            valid_q  <= valid_d;
            prev_q   <= prev_d;
        end
    end

    // reflex outputs: one cycle from live count to pin, far inside 20 us
    generate
        for (genvar k = 0; k < N_REFLEX; k++) begin : g_reflex
            logic hit;
            logic out_d;
            always_comb begin
                case (period_meter_pkg::trigger_e'(mode_q[k]))
                    period_meter_pkg::TRIG_AT_OR_ABOVE: hit = cnt_q >= thr_q[k];
                    period_meter_pkg::TRIG_BELOW:       hit = cnt_q < thr_q[k];
                    period_meter_pkg::TRIG_EQUAL:       hit = cnt_q == thr_q[k];
                    default:                            hit = 1'b0;
                endcase
                out_d = reflex_out[k];
                if (!ctrl_q[`PM_CTRL_CMP_EN]) begin
                    out_d = 1'b0;
                end else if (!ctrl_q[`PM_CTRL_CMP_SUSP]) begin
                    out_d = hit;
                end
            end
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    reflex_out[k] <= 1'b0;
                end else begin
                    reflex_out[k] <= out_d;
                end
            end
        end
    endgenerate

    // register read decode
    logic [31:0] rd_val;
    logic        rd_hit;
    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `PM_CTRL_OFS:   rd_val = {24'h0, ctrl_q};
            `PM_SEL_OFS:    rd_val = {24'h0, sel_q};
            `PM_PERIOD_OFS: rd_val = period_q;
            `PM_LIVE_OFS:   rd_val = cnt_q;
            `PM_STATUS_OFS: begin
                rd_val[`PM_ST_RUN]   = enable_cond;
                rd_val[`PM_ST_VALID] = valid_q;
                rd_val[`PM_ST_BUSY]  = st_q == period_meter_pkg::MEAS_TIMING;
                rd_val[`PM_ST_READY] = meas_ok;
                rd_val[`PM_ST_REFLEX_LO +: N_REFLEX] = reflex_out;
            end
            default:        rd_hit = 1'b0;
        endcase
        for (int k = 0; k < N_REFLEX; k++) begin
            if (s_axi_araddr == `PM_REFLEX_BASE + 8'(k) * `PM_REFLEX_STRIDE) begin
                rd_val = thr_q[k];
                rd_hit = 1'b1;
            end
            if (s_axi_araddr == `PM_REFLEX_BASE + 8'(k) * `PM_REFLEX_STRIDE
                    + `PM_REFLEX_MODE) begin
                rd_val = {30'h0, mode_q[k]};
                rd_hit = 1'b1;
            end
        end
    end

    // bus slave and configuration writes
    always_comb begin
        logic hit;
        hit       = 1'b0;
        ctrl_d    = ctrl_q;
        sel_d     = sel_q;
        thr_d     = thr_q;
        mode_d    = mode_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        bvalid_d  = s_axi_bvalid;
        bresp_d   = s_axi_bresp;
        rvalid_d  = s_axi_rvalid;
        rdata_d   = s_axi_rdata;
        rresp_d   = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (aw_held_q && w_held_q && !s_axi_bvalid) begin
            if (awaddr_q == `PM_CTRL_OFS) begin
                hit = 1'b1;
                if (wstrb_q[0]) ctrl_d = wdata_q[7:0];
            end
            if (awaddr_q == `PM_SEL_OFS) begin
                hit = 1'b1;
                if (wstrb_q[0]) sel_d = wdata_q[7:0];
            end
            if (awaddr_q == `PM_PERIOD_OFS || awaddr_q == `PM_STATUS_OFS ||
                    awaddr_q == `PM_LIVE_OFS) begin
                hit = 1'b1;
            end
            for (int k = 0; k < N_REFLEX; k++) begin
                if (awaddr_q == `PM_REFLEX_BASE + 8'(k) * `PM_REFLEX_STRIDE) begin
                    hit = 1'b1;
                    for (int b = 0; b < 4; b++) begin
                        if (wstrb_q[b]) thr_d[k][8*b +: 8] = wdata_q[8*b +: 8];
                    end
                end
                if (awaddr_q == `PM_REFLEX_BASE + 8'(k) * `PM_REFLEX_STRIDE
                        + `PM_REFLEX_MODE) begin
                    hit = 1'b1;
                    if (wstrb_q[0]) mode_d[k] = wdata_q[1:0];
                end
            end
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = hit ? RESP_OK : RESP_ERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rdata_d  = rd_val;
            rresp_d  = rd_hit ? RESP_OK : RESP_ERR;
        end
        awready_d = !aw_held_d && !bvalid_d;
        wready_d  = !w_held_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q        <= `PM_CTRL_RESET;
            sel_q         <= `PM_SEL_RESET;
            thr_q         <= '{default: 32'h0};
            mode_q        <= '{default: 2'h0};
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0;
            wstrb_q       <= 4'h0;
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'b00;
        end else begin
            ctrl_q        <= ctrl_d;
            sel_q         <= sel_d;
            thr_q         <= thr_d;
            mode_q        <= mode_d;
            awaddr_q      <= awaddr_d;
            wdata_q       <= wdata_d;
            wstrb_q       <= wstrb_d;
            aw_held_q     <= aw_held_d;
            w_held_q      <= w_held_d;
            s_axi_awready <= awready_d;
            s_axi_wready  <= wready_d;
            s_axi_bvalid  <= bvalid_d;
            s_axi_bresp   <= bresp_d;
            s_axi_arready <= arready_d;
            s_axi_rvalid  <= rvalid_d;
            s_axi_rdata   <= rdata_d;
            s_axi_rresp   <= rresp_d;
        end
    end
endmodule

// ### tb/field_pulse_model.sv
/*
 * field side of the period meter: levels on the filtered field inputs.
 * assumes the bench calls put just after a rising clock edge.
 */
`timescale 1ns/1ps
module field_pulse_model #(
    parameter int N = 12
) (
    input  wire logic   clock, // module clock
    output logic [N-1:0] field  // field input levels
);
    // every pin is driven: the upstream filter never leaves one floating
    initial field = '0;

    // a level moves only after an edge, as a synchronised pin would
    task automatic put(input int idx, input logic lvl);
        @(posedge clock);
        field[idx] <= lvl;
    endtask
endmodule

// ### tb/period_meter_monitor.sv
/*
 * checker on the period meter ports: register bus timing, reflex gating.
 * assumes bind into period_meter_capture, control word at offset 8'h00.
 */
`timescale 1ns/1ps
module period_meter_monitor #(
    parameter int N_REFLEX = 4
) (
    input wire logic                clock,         // module clock
    input wire logic                rst_b,         // reset, active low
    input wire logic [N_REFLEX-1:0] reflex_out,    // reflex outputs
    input wire logic [7:0]          s_axi_awaddr,  // write address
    input wire logic                s_axi_awvalid, // aw valid
    input wire logic                s_axi_awready, // aw ready
    input wire logic [31:0]         s_axi_wdata,   // write data
    input wire logic                s_axi_wvalid,  // w valid
    input wire logic                s_axi_wready,  // w ready
    input wire logic [1:0]          s_axi_bresp,   // write response
    input wire logic                s_axi_bvalid,  // b valid
    input wire logic                s_axi_bready,  // b ready
    input wire logic [7:0]          s_axi_araddr,  // read address
    input wire logic                s_axi_arvalid, // ar valid
    input wire logic                s_axi_arready, // ar ready
    input wire logic [31:0]         s_axi_rdata,   // read data
    input wire logic [1:0]          s_axi_rresp,   // read response
    input wire logic                s_axi_rvalid,  // r valid
    input wire logic                s_axi_rready   // r ready
);
    logic [7:0] adr_q, adr_d;
    logic [7:0] dat_q, dat_d;
    logic [7:0] ctl_q, ctl_d;

    // control shadow commits at the response handshake, so it never runs
    // ahead of the design's own register
    always_comb begin
        adr_d = adr_q;
        dat_d = dat_q;
        ctl_d = ctl_q;
        if (s_axi_awvalid && s_axi_awready) adr_d = s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) dat_d = s_axi_wdata[7:0];
        if (s_axi_bvalid && s_axi_bready && adr_q == 8'h00) ctl_d = dat_q;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            {adr_q, dat_q, ctl_q} <= 24'h0;
        else
            {adr_q, dat_q, ctl_q} <= {adr_d, dat_d, ctl_d};
    end

    function automatic logic mapped(input logic [7:0] a);
        return a[1:0] == 2'b00 && (a <= 8'h10 ||
               (a >= 8'h20 && int'(a) < 32 + 8 * N_REFLEX));
    endfunction

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    sequence aw_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_read_answer: assert property (
        ar_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not one cycle after address");
    a_read_okay: assert property (
        ar_taken ##0 mapped(s_axi_araddr) |=> s_axi_rresp == 2'b00)
        else $error("mapped read not answered okay");
    a_read_error: assert property (ar_taken ##0 !mapped(s_axi_araddr)
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_write_answer: assert property (aw_taken ##0 mapped(s_axi_awaddr)
        |-> ##[1:2] s_axi_bvalid && s_axi_bresp == 2'b00)
        else $error("mapped write not answered okay in time");
    a_write_error: assert property (aw_taken ##0 !mapped(s_axi_awaddr)
        |-> ##[1:2] s_axi_bvalid && s_axi_bresp == 2'b10)
        else $error("unmapped write not refused in time");
    a_write_block: assert property (
        aw_taken |=> (!s_axi_awready && !s_axi_wready) [*2])
        else $error("new write accepted before the answer");
    a_reflex_gated: assert property (
        !ctl_q[5] && !s_axi_bvalid |-> reflex_out == '0)
        else $error("reflex output active with compare off");
    a_reflex_hold: assert property (
        (ctl_q[6:5] == 2'b11 && !s_axi_bvalid) [*2] |=> $stable(reflex_out))
        else $error("reflex output moved while compare suspended");
endmodule

bind period_meter_capture period_meter_monitor #(
    .N_REFLEX(N_REFLEX)
) mon (.*);

// ### tb/tb.sv
/*
 * bench for the period meter: register bus tasks and measurement runs.
 * assumes the field model drives field_in and short tick parameters.
 */
`timescale 1ns/1ps
module tb;
    localparam int R100 = 20;
    localparam int R1K  = 40;
    logic        clock, rst_b;
    logic [11:0] field_in;
    logic [3:0]  reflex_out, s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    int          miscompares = 0, compares = 0, cyc = 0, t0;
    int          rcyc [5] = '{5, 50, 500, R100, R1K};
    logic [7:0]  regs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h24,
                              8'h3c};

    period_meter_capture #(
        .TICK_100US_CYC(R100),
        .TICK_1MS_CYC  (R1K)
    ) DUT (.*);
    field_pulse_model fm (.clock(clock), .field(field_in));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        if (miscompares == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        forever begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        rsp = s_axi_bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d   = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp,
                      input string nm);
        rd(a);
        chk(nm, exp, d);
        chk("rresp", 32'h0, rsp);
    endtask

    task automatic wait_to(input int t);
        while (cyc < t) @(posedge clock);
    endtask

    // the fall lands one edge after hi, so counts sit mid-tick
    task automatic pulse(input int idx, input int hi);
        fm.put(idx, 1'b1);
        t0 = cyc;
        wait_to(t0 + hi);
        fm.put(idx, 1'b0);
        repeat (3) @(posedge clock);
    endtask

    initial begin
        rst_b = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        foreach (regs[i]) rc(regs[i], 32'h0, "reset value");
        rd(8'h14);
        chk("unmapped rdata", 32'h0, d);
        chk("unmapped rresp", 32'h2, rsp);
        wr(8'h40, 32'h1);
        chk("unmapped bresp", 32'h2, rsp);
        wr(8'h08, 32'hffff_ffff);
        rc(8'h08, 32'h0, "read-only period");
        wr(8'h00, 32'h80);
        pulse(0, 17);
        rc(8'h08, 32'h0, "unassigned period");
        rc(8'h0c, 32'h01, "unassigned status");
        wr(8'h04, 32'h01);
        rc(8'h0c, 32'h09, "assigned status");
        for (int r = 0; r < 5; r++) begin
            wr(8'h00, 32'h80 | 32'(r << 2));
            fm.put(0, 1'b1);
            t0 = cyc;
            rc(8'h08, (r == 0) ? 0 : r + 1, "period mid-event");
            wait_to(t0 + (r + 2) * rcyc[r] + rcyc[r] / 2);
            fm.put(0, 1'b0);
            repeat (3) @(posedge clock);
            rc(8'h08, r + 2, "period");
        end
        rc(8'h10, 32'h6, "live count");
        rc(8'h0c, 32'h0b, "status");
        wr(8'h00, 32'h82);
        pulse(0, 8);
        wait_to(t0 + 22);
        pulse(0, 8);
        rc(8'h08, 32'h4, "edge period");
        wr(8'h00, 32'h00);
        wr(8'h00, 32'h80);
        fm.put(0, 1'b1);
        repeat (20) @(posedge clock);
        wr(8'h00, 32'h00);
        rc(8'h0c, 32'h08, "status disabled");
        wr(8'h00, 32'h80);
        fm.put(0, 1'b0);
        repeat (3) @(posedge clock);
        rc(8'h08, 32'h4, "abandoned");
        pulse(0, 12);
        rc(8'h08, 32'h2, "after abandon");
        wr(8'h04, 32'h21);
        wr(8'h00, 32'h01);
        pulse(0, 17);
        rc(8'h08, 32'h2, "gate low");
        fm.put(1, 1'b1);
        repeat (2) @(posedge clock);
        pulse(0, 22);
        rc(8'h08, 32'h4, "gate high");
        rc(8'h0c, 32'h0b, "gate status");
        fm.put(1, 1'b0);
        wr(8'h00, 32'ha0);
        for (int k = 0; k < 4; k++) begin
            wr(8'(8'h20 + 8 * k), (k == 0) ? 32'h6 : 32'h4);
            wr(8'(8'h24 + 8 * k), 32'(3 - k));
        end
        pulse(0, 32);
        chk("reflex", 32'h5, reflex_out);
        rc(8'h0c, 32'h5b, "reflex status");
        fm.put(0, 1'b1);
        t0 = cyc;
        wait_to(t0 + 15);
        chk("reflex mid-event", 32'h2, reflex_out);
        wait_to(t0 + 33);
        fm.put(0, 1'b0);
        repeat (3) @(posedge clock);
        wr(8'h00, 32'he0);
        wr(8'h28, 32'h10);
        chk("reflex held", 32'h5, reflex_out);
        wr(8'h00, 32'ha0);
        repeat (2) @(posedge clock);
        chk("reflex resumed", 32'h7, reflex_out);
        wr(8'h00, 32'h80);
        repeat (2) @(posedge clock);
        chk("reflex off", 32'h0, reflex_out);
        // only the two low lanes of the threshold may change
        s_axi_wstrb <= 4'h3;
        wr(8'h20, 32'hffff_ffff);
        s_axi_wstrb <= 4'hf;
        rc(8'h20, 32'h0000_ffff, "lane write");
        end_of_test();
    end
endmodule
